// ### logic/timer_pkg.sv
// constants, types and register map of the dual timer/counter unit
// assumes a core clock with one-clock machine-cycle and T10 phase strobes
//
// Overview of operation
// - counter operation advances the count on each detected count-pin event
// - timer operation increments the count once per machine cycle
// - mode register: timer 1 gate, select, mode in 7..4; timer 0 in 3..0
// - with gate set, count only while external line high and run bit set
// - select 1 counts external events, select 0 counts machine cycles
// - mode 00 13-bit, 01 16-bit, 10 8-bit auto-reload, 11 mode 3
// - auto-reload counts low byte; overflow sets flag, copies high into low
// - timer 1 in mode 3 halts and holds its count
// - rollover to zero sets the timer overflow flag in the control register
// - control bits: timer 1 overflow 7, run 6; timer 0 overflow 5, run 4
// - overflow flag clears when the processor vectors to that timer routine
// - edge flags bits 3 and 1 set on external edge, cleared when serviced
// - type bits 2 and 0 pick falling edge or low level per external line
// - count pins of timers 0 and 1 sampled once per machine cycle at T10
// - count on high sample then low sample; two machine cycles per event
// - 13-bit mode: five low bits of low byte prescale, high byte counts
// - counting enabled when run is 1 and gate is 0 or line is 1
// - 16-bit mode uses all sixteen bits without prescaler
// - mode 3 splits timer 0; high byte counts cycles on timer 1 run, sets its flag
package timer_pkg;

  // register map
  localparam logic [7:0] RUN_FLAGS_ADDR = 8'h88;
  localparam logic [7:0] MODE_CFG_ADDR  = 8'h89;
  localparam logic [7:0] TMR0_LOW_ADDR  = 8'h8A;
  localparam logic [7:0] TMR0_HIGH_ADDR = 8'h8B;
  localparam logic [7:0] TMR1_LOW_ADDR  = 8'h8C;
  localparam logic [7:0] TMR1_HIGH_ADDR = 8'h8D;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // run/flags field positions, timer 1 and line 1 sit at +STEP
  localparam int TYPE0_BIT = 0;
  localparam int EDGE0_BIT = 1;
  localparam int RUN0_BIT  = 4;
  localparam int OVF0_BIT  = 5;
  localparam int CH_STEP   = 2;

  // mode config: nibble per timer
  localparam int CFG_WIDTH  = 4;
  localparam int PRESC_BITS = 5;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD8,
    MODE_SPLIT
  } timer_mode_type;

  typedef struct packed {
    logic           gate;
    logic           count_sel;
    timer_mode_type mode;
  } timer_cfg_type;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } count_type;

  typedef struct packed {
    logic      ovf;
    count_type cnt;
  } step_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_type;

endpackage : timer_pkg

// ### logic/dual_timer_counter_unit.sv
// two 16-bit timer/counters with shared mode and run/flag registers
// assumes synchronous pins, strobes from the core clock generator
`timescale 1ns/100ps
module dual_timer_counter_unit (
  // clock, reset, enable
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       CE_I,
  // machine-cycle timing
  input  wire logic       MCYC_STB_I,
  input  wire logic       PH10_STB_I,
  // pins
  input  wire logic       TIMER0_COUNT_PIN_I,
  input  wire logic       TIMER1_COUNT_PIN_I,
  input  wire logic       EXT_LINE_0_I,
  input  wire logic       EXT_LINE_1_I,
  // interrupt vector acknowledges
  input  wire logic       TIMER0_VECTOR_I,
  input  wire logic       TIMER1_VECTOR_I,
  input  wire logic       EXT0_VECTOR_I,
  input  wire logic       EXT1_VECTOR_I,
  // register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output      logic [7:0] RDATA_O,
  // flags
  output      logic       TIMER0_OVF_O,
  output      logic       TIMER1_OVF_O,
  output      logic       EXT0_REQ_O,
  output      logic       EXT1_REQ_O
);

  timer_pkg::bus_req_type req;
  logic [7:0]             timer_run_flags_r;
  logic [7:0]             timer_mode_config_r;
  logic [7:0]             run_flags_nxt;
  timer_pkg::count_type   cnt_r   [2];
  timer_pkg::count_type   cnt_nxt [2];
  logic [3:0]             smp_r;
  logic [3:0]             fall_r;
  logic [7:0]             rdata_r;
  logic [7:0]             rd_mux;
  logic [3:0]             pins;
  logic                   wr_rf;
  logic                   wr_mode;
  logic [1:0]             wr_lo;
  logic [1:0]             wr_hi;
  logic [1:0]             inc;
  logic [1:0]             ovf_set;
  logic [1:0]             ext_set;
  logic [1:0]             ack_ovf;
  logic [1:0]             ack_ext;
  logic                   split0;
  logic                   split_hi_inc;
  timer_pkg::step_type    step_w  [2];
  timer_pkg::timer_cfg_type cfg   [2];

  // one count step in the selected mode
  function automatic timer_pkg::step_type step(
    input timer_pkg::count_type     c,
    input timer_pkg::timer_mode_type m
  );
    timer_pkg::step_type r;
    r.cnt = c;
    r.ovf = 1'b0;
    case (m)
      timer_pkg::MODE_13BIT: begin
        // prescaler in low five bits, carry into high byte
        if (c.lo[timer_pkg::PRESC_BITS-1:0] == 5'h1F) begin
          r.cnt.lo = {c.lo[7:timer_pkg::PRESC_BITS], 5'h00};
          r.cnt.hi = c.hi + 8'h01;
          r.ovf    = (c.hi == 8'hFF);
        end else begin
          r.cnt.lo = {c.lo[7:timer_pkg::PRESC_BITS],
                      c.lo[timer_pkg::PRESC_BITS-1:0] + 5'h01};
        end
      end
      timer_pkg::MODE_16BIT: begin
        {r.ovf, r.cnt} = {1'b0, c} + 17'h00001;
      end
      timer_pkg::MODE_RELOAD8: begin
        // reload low byte from high byte, high byte unchanged
        if (c.lo == 8'hFF) begin
          r.cnt.lo = c.hi;
          r.ovf    = 1'b1;
        end else begin
          r.cnt.lo = c.lo + 8'h01;
        end
      end
      timer_pkg::MODE_SPLIT: begin
        // low byte alone as 8-bit counter
        r.cnt.lo = c.lo + 8'h01;
        r.ovf    = (c.lo == 8'hFF);
      end
      default: begin
        r.cnt = c;
      end
    endcase
    return r;
  endfunction : step

  // bus decode
  assign req     = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign wr_rf   = req.wr & (req.addr == timer_pkg::RUN_FLAGS_ADDR);
  assign wr_mode = req.wr & (req.addr == timer_pkg::MODE_CFG_ADDR);
  assign wr_lo[0] = req.wr & (req.addr == timer_pkg::TMR0_LOW_ADDR);
  assign wr_hi[0] = req.wr & (req.addr == timer_pkg::TMR0_HIGH_ADDR);
  assign wr_lo[1] = req.wr & (req.addr == timer_pkg::TMR1_LOW_ADDR);
  assign wr_hi[1] = req.wr & (req.addr == timer_pkg::TMR1_HIGH_ADDR);

  // read select, unmapped reads return zero
  assign rd_mux =
    (req.addr == timer_pkg::RUN_FLAGS_ADDR) ? timer_run_flags_r :
    (req.addr == timer_pkg::MODE_CFG_ADDR)  ? timer_mode_config_r :
    (req.addr == timer_pkg::TMR0_LOW_ADDR)  ? cnt_r[0].lo :
    (req.addr == timer_pkg::TMR0_HIGH_ADDR) ? cnt_r[0].hi :
    (req.addr == timer_pkg::TMR1_LOW_ADDR)  ? cnt_r[1].lo :
    (req.addr == timer_pkg::TMR1_HIGH_ADDR) ? cnt_r[1].hi : 8'h00;

  // sampled pins: ext lines in 3..2, count pins in 1..0
  assign pins = {EXT_LINE_1_I, EXT_LINE_0_I,
                 TIMER1_COUNT_PIN_I, TIMER0_COUNT_PIN_I};

  assign ack_ovf = {TIMER1_VECTOR_I, TIMER0_VECTOR_I};
  assign ack_ext = {EXT1_VECTOR_I, EXT0_VECTOR_I};

  // timer 0 in mode 3 lends its high byte to timer 1 controls
  assign split0       = (cfg[0].mode == timer_pkg::MODE_SPLIT);
  assign split_hi_inc = split0 & MCYC_STB_I
                        & timer_run_flags_r[timer_pkg::RUN0_BIT
                                            + timer_pkg::CH_STEP];

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_timer
      logic run;
      logic gate_ok;
      logic tick;
      logic halt;

      // mode nibble per timer
      assign cfg[i] = timer_pkg::timer_cfg_type'(
        timer_mode_config_r[timer_pkg::CFG_WIDTH*i +: timer_pkg::CFG_WIDTH]);
      assign run     = timer_run_flags_r[timer_pkg::RUN0_BIT
                                         + timer_pkg::CH_STEP*i];
      assign gate_ok = ~cfg[i].gate | smp_r[2+i];
      // event count or machine-cycle count
      assign tick    = MCYC_STB_I & (~cfg[i].count_sel | fall_r[i]);
      assign halt    = (i == 1) && (cfg[1].mode == timer_pkg::MODE_SPLIT);
      assign inc[i]  = run & gate_ok & tick & ~halt;
      assign step_w[i] = step(cnt_r[i], cfg[i].mode);

      always_comb begin
        cnt_nxt[i] = cnt_r[i];
        if (inc[i]) begin
          cnt_nxt[i] = step_w[i].cnt;
        end
        if ((i == 0) && split0) begin
          cnt_nxt[i].hi = cnt_r[i].hi + {7'h00, split_hi_inc};
        end
        if (wr_lo[i]) begin
          cnt_nxt[i].lo = req.wdata;
        end
        if (wr_hi[i]) begin
          cnt_nxt[i].hi = req.wdata;
        end
      end

      // falling edge or low level on the external line
      assign ext_set[i] = PH10_STB_I & ~pins[2+i]
        & (~timer_run_flags_r[timer_pkg::TYPE0_BIT + timer_pkg::CH_STEP*i]
           | smp_r[2+i]);
    end
  endgenerate

  // overflow to zero sets the flag
  assign ovf_set[0] = inc[0] & step_w[0].ovf;
  assign ovf_set[1] = split0 ? (split_hi_inc & (cnt_r[0].hi == 8'hFF))
                             : (inc[1] & step_w[1].ovf);

  // flag update: software write, then acknowledges, hardware set wins
  always_comb begin
    run_flags_nxt = wr_rf ? req.wdata : timer_run_flags_r;
    for (int k = 0; k < 2; k++) begin
      if (ack_ovf[k]) begin
        run_flags_nxt[timer_pkg::OVF0_BIT + timer_pkg::CH_STEP*k] = 1'b0;
      end
      if (ack_ext[k]) begin
        run_flags_nxt[timer_pkg::EDGE0_BIT + timer_pkg::CH_STEP*k] = 1'b0;
      end
      if (ovf_set[k]) begin
        run_flags_nxt[timer_pkg::OVF0_BIT + timer_pkg::CH_STEP*k] = 1'b1;
      end
      if (ext_set[k]) begin
        run_flags_nxt[timer_pkg::EDGE0_BIT + timer_pkg::CH_STEP*k] = 1'b1;
      end
    end
  end

  // state registers
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      timer_run_flags_r   <= timer_pkg::REG_RESET;
      timer_mode_config_r <= timer_pkg::REG_RESET;
      cnt_r[0]            <= '0;
      cnt_r[1]            <= '0;
      smp_r               <= 4'h0;
      fall_r              <= 4'h0;
      rdata_r             <= 8'h00;
    end else if (CE_I) begin
      timer_run_flags_r <= run_flags_nxt;
      if (wr_mode) begin
        timer_mode_config_r <= req.wdata;
      end
      cnt_r[0] <= cnt_nxt[0];
      cnt_r[1] <= cnt_nxt[1];
      if (PH10_STB_I) begin
        smp_r  <= pins;
        fall_r <= smp_r & ~pins;
      end
      rdata_r <= req.rd ? rd_mux : 8'h00;
    end
  end

  assign RDATA_O      = rdata_r;
  assign TIMER0_OVF_O = timer_run_flags_r[timer_pkg::OVF0_BIT];
  assign TIMER1_OVF_O = timer_run_flags_r[timer_pkg::OVF0_BIT
                                          + timer_pkg::CH_STEP];
  assign EXT0_REQ_O   = timer_run_flags_r[timer_pkg::EDGE0_BIT];
  assign EXT1_REQ_O   = timer_run_flags_r[timer_pkg::EDGE0_BIT
                                          + timer_pkg::CH_STEP];

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  logic t0_wr;
  assign t0_wr = wr_lo[0] | wr_hi[0];

  property p_mode_read;
    CE_I && req.rd && req.addr == timer_pkg::MODE_CFG_ADDR
      |=> RDATA_O == $past(timer_mode_config_r);
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode register read data wrong");

  property p_timer_inc;
    CE_I && MCYC_STB_I && timer_run_flags_r[timer_pkg::RUN0_BIT]
      && !cfg[0].gate && !cfg[0].count_sel && !t0_wr
      && cfg[0].mode == timer_pkg::MODE_16BIT && cnt_r[0] != 16'hFFFF
      |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001;
  endproperty
  a_timer_inc: assert property (p_timer_inc)
    else $error("timer did not step on machine cycle");

  property p_no_event;
    CE_I && cfg[0].count_sel && !fall_r[0] && !split0 && !t0_wr
      |=> $stable(cnt_r[0]);
  endproperty
  a_no_event: assert property (p_no_event)
    else $error("counter moved without a sampled fall");

  property p_gate;
    CE_I && cfg[0].gate && !smp_r[2] && !split0 && !t0_wr
      |=> $stable(cnt_r[0]);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated timer counted with line low");

  property p_reload;
    CE_I && inc[0] && cfg[0].mode == timer_pkg::MODE_RELOAD8
      && cnt_r[0].lo == 8'hFF && !t0_wr
      |=> cnt_r[0].lo == $past(cnt_r[0].hi) && TIMER0_OVF_O
          && $stable(cnt_r[0].hi);
  endproperty
  a_reload: assert property (p_reload)
    else $error("auto-reload wrong");

  property p_halt1;
    CE_I && cfg[1].mode == timer_pkg::MODE_SPLIT
      && !wr_lo[1] && !wr_hi[1]
      |=> $stable(cnt_r[1]);
  endproperty
  a_halt1: assert property (p_halt1)
    else $error("timer 1 moved in mode 3");

  property p_ovf_set;
    CE_I && ovf_set[1] |=> TIMER1_OVF_O;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set");

  property p_ack_clear;
    CE_I && TIMER0_VECTOR_I && !ovf_set[0] && !wr_rf |=> !TIMER0_OVF_O;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("overflow flag not cleared on vector");

  property p_edge;
    CE_I && PH10_STB_I && timer_run_flags_r[timer_pkg::TYPE0_BIT]
      && smp_r[2] && !EXT_LINE_0_I |=> EXT0_REQ_O;
  endproperty
  a_edge: assert property (p_edge)
    else $error("edge flag not set on falling edge");

  property p_ovf0_set;
    CE_I && ovf_set[0] |=> TIMER0_OVF_O;
  endproperty
  a_ovf0_set: assert property (p_ovf0_set)
    else $error("timer 0 overflow flag not set");

  property p_run_write;
    CE_I && wr_rf
      |=> timer_run_flags_r[timer_pkg::RUN0_BIT]
          == $past(req.wdata[timer_pkg::RUN0_BIT]);
  endproperty
  a_run_write: assert property (p_run_write)
    else $error("run bit not taken from software write");

  property p_stopped;
    CE_I && !timer_run_flags_r[timer_pkg::RUN0_BIT] && !split0 && !t0_wr
      |=> $stable(cnt_r[0]);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped timer counted");

  property p_event_count;
    CE_I && MCYC_STB_I && cfg[0].count_sel && fall_r[0] && !cfg[0].gate
      && timer_run_flags_r[timer_pkg::RUN0_BIT] && !t0_wr
      && cfg[0].mode == timer_pkg::MODE_16BIT
      |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001;
  endproperty
  a_event_count: assert property (p_event_count)
    else $error("counter missed a sampled fall");

  property p_sample;
    CE_I && PH10_STB_I
      |=> smp_r == $past(pins) && fall_r == ($past(smp_r) & ~$past(pins));
  endproperty
  a_sample: assert property (p_sample)
    else $error("pin sample or fall detect wrong");

  property p_prescale;
    CE_I && inc[0] && cfg[0].mode == timer_pkg::MODE_13BIT && !t0_wr
      && cnt_r[0].lo[timer_pkg::PRESC_BITS-1:0] == 5'h1F
      |=> cnt_r[0].lo[timer_pkg::PRESC_BITS-1:0] == 5'h00
          && cnt_r[0].hi == $past(cnt_r[0].hi) + 8'h01
          && $stable(cnt_r[0].lo[7:timer_pkg::PRESC_BITS]);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler carry wrong");

  property p_split_high;
    CE_I && split0 && MCYC_STB_I && !t0_wr
      && timer_run_flags_r[timer_pkg::RUN0_BIT + timer_pkg::CH_STEP]
      |=> cnt_r[0].hi == $past(cnt_r[0].hi) + 8'h01;
  endproperty
  a_split_high: assert property (p_split_high)
    else $error("split high byte did not count");

  property p_level;
    CE_I && PH10_STB_I && !timer_run_flags_r[timer_pkg::TYPE0_BIT]
      && !EXT_LINE_0_I |=> EXT0_REQ_O;
  endproperty
  a_level: assert property (p_level)
    else $error("low level did not raise the line flag");

  property p_ext_clear;
    CE_I && EXT0_VECTOR_I && !ext_set[0] && !wr_rf |=> !EXT0_REQ_O;
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("line flag not cleared on service");

  property p_gate_open;
    CE_I && MCYC_STB_I && cfg[0].gate && smp_r[2] && !cfg[0].count_sel
      && timer_run_flags_r[timer_pkg::RUN0_BIT] && !t0_wr
      && cfg[0].mode == timer_pkg::MODE_16BIT
      |=> cnt_r[0] == $past(cnt_r[0]) + 16'h0001;
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("gated timer idle with line high");

endmodule : dual_timer_counter_unit

// ### testbench/pin_model.sv
// model of the count pins and external lines around the timer unit
// assumes the bench calls its tasks from the CLK_I domain
`timescale 1ns/100ps
module pin_model (
  // clock
  input  wire logic CLK_I,
  // pins, idle high as with a pull-up
  output      logic CNT0_O,
  output      logic CNT1_O,
  output      logic LINE0_O,
  output      logic LINE1_O
);
  logic [1:0] cnt_r  = 2'h3;
  logic [1:0] line_r = 2'h3;

  assign CNT0_O  = cnt_r[0];
  assign CNT1_O  = cnt_r[1];
  assign LINE0_O = line_r[0];
  assign LINE1_O = line_r[1];

  task set_line(input int i, input logic v);
    @(posedge CLK_I);
    line_r[i] <= v;
  endtask : set_line

  // one falling edge, low and high phases held hold clocks each
  task count_event(input int i, input int hold);
    @(posedge CLK_I);
    cnt_r[i] <= 1'b0;
    repeat (hold) @(posedge CLK_I);
    cnt_r[i] <= 1'b1;
    repeat (hold) @(posedge CLK_I);
  endtask : count_event
endmodule : pin_model

// ### testbench/tb.sv
// self-checking bench for the dual timer/counter unit
// assumes pin_model drives the count pins and external lines
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] RUN = timer_pkg::RUN_FLAGS_ADDR;
  localparam logic [7:0] CFG = timer_pkg::MODE_CFG_ADDR;
  localparam logic [7:0] T0L = timer_pkg::TMR0_LOW_ADDR;
  localparam logic [7:0] T1L = timer_pkg::TMR1_LOW_ADDR;
  logic       CLK_I      = 1'b0;
  logic       SYS_RST_I  = 1'b1;
  logic       CE_I       = 1'b1;
  logic       MCYC_STB_I = 1'b0;
  logic       PH10_STB_I = 1'b0;
  logic [3:0] vec_r      = 4'h0;
  logic [7:0] ADDR_I     = 8'h00;
  logic [7:0] WDATA_I    = 8'h00;
  logic       WR_I       = 1'b0;
  logic       RD_I       = 1'b0;
  logic [3:0] ph         = 4'h0;
  wire  [7:0] RDATA_O;
  wire  [3:0] flg;
  wire        cnt0, cnt1, line0, line1;
  int         mc         = 0;
  int         num_errors = 0;
  int         num_checks = 0;

  always #5 CLK_I = ~CLK_I;

  // twelve clocks per machine cycle, sample phase then step
  always @(posedge CLK_I) begin
    ph         <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
    PH10_STB_I <= (ph == 4'h8);
    MCYC_STB_I <= (ph == 4'hA);
    if (MCYC_STB_I) mc <= mc + 1;
  end

  pin_model pins (.CLK_I(CLK_I), .CNT0_O(cnt0), .CNT1_O(cnt1),
                  .LINE0_O(line0), .LINE1_O(line1));

  dual_timer_counter_unit dut (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
    .MCYC_STB_I(MCYC_STB_I), .PH10_STB_I(PH10_STB_I),
    .TIMER0_COUNT_PIN_I(cnt0), .TIMER1_COUNT_PIN_I(cnt1),
    .EXT_LINE_0_I(line0), .EXT_LINE_1_I(line1),
    .TIMER0_VECTOR_I(vec_r[0]), .TIMER1_VECTOR_I(vec_r[1]),
    .EXT0_VECTOR_I(vec_r[2]), .EXT1_VECTOR_I(vec_r[3]),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .TIMER0_OVF_O(flg[0]), .TIMER1_OVF_O(flg[1]),
    .EXT0_REQ_O(flg[2]), .EXT1_REQ_O(flg[3]));

  task final_report();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    ADDR_I  <= a;
    WDATA_I <= d;
    WR_I    <= 1'b1;
    @(posedge CLK_I);
    WR_I    <= 1'b0;
  endtask : wr

  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I   <= 1'b1;
    @(posedge CLK_I);
    RD_I   <= 1'b0;
    #1;
    check({8'h00, RDATA_O}, {8'h00, e});
  endtask : rchk

  task vec(input int i);
    @(posedge CLK_I);
    vec_r[i] <= 1'b1;
    @(posedge CLK_I);
    vec_r[i] <= 1'b0;
    @(posedge CLK_I);
    #1;
    check({15'h0, flg[i]}, 16'h0000);
  endtask : vec

  // waits for flag sel; n >= 0 also checks the machine cycles taken
  task wait_flag(input int sel, input int n);
    int start;
    int k;
    #1;
    start = mc;
    k = 0;
    while (flg[sel] !== 1'b1) begin
      @(posedge CLK_I);
      #1;
      k++;
      if (k > 600) begin
        num_errors++;
        final_report();
      end
    end
    if (n >= 0) check(16'(mc - start), 16'(n));
  endtask : wait_flag

  task t_mode(input int s, input logic [7:0] cfg, lo, hi, input int n,
              input logic [7:0] lo_e, hi_e);
    logic [7:0] a;
    a = s ? T1L : T0L;
    wr(a, lo);
    wr(a + 8'h01, hi);
    wr(CFG, cfg);
    wr(RUN, s ? 8'h40 : 8'h10);
    wait_flag(s, n);
    wr(RUN, s ? 8'h80 : 8'h20);
    rchk(a, lo_e);
    rchk(a + 8'h01, hi_e);
    vec(s);
  endtask : t_mode

  task t_reset();
    for (int a = 0; a < 7; a++) rchk(RUN + 8'(a), 8'h00);
    check({12'h000, flg}, 16'h0000);
  endtask : t_reset

  task t_regs();
    wr(CFG, 8'hA5);
    rchk(CFG, 8'hA5);
    wr(CFG, 8'h5A);
    rchk(CFG, 8'h5A);
    wr(RUN, 8'h05);
    rchk(RUN, 8'h05);
    wr(RUN, 8'h00);
  endtask : t_regs

  task t_modes();
    t_mode(0, 8'h00, 8'hFE, 8'hFF, 2, 8'hE0, 8'h00);
    t_mode(0, 8'h01, 8'hFD, 8'hFF, 3, 8'h00, 8'h00);
    t_mode(0, 8'h02, 8'hFE, 8'h40, 2, 8'h40, 8'h40);
    t_mode(1, 8'h20, 8'hFF, 8'h12, 1, 8'h12, 8'h12);
  endtask : t_modes

  task t_split();
    wr(T1L, 8'h55);
    wr(T0L, 8'h00);
    wr(T0L + 8'h01, 8'hFF);
    wr(CFG, 8'h33);
    wr(RUN, 8'h40);
    wait_flag(1, 1);
    wr(RUN, 8'h80);
    rchk(T1L, 8'h55);
    rchk(T0L, 8'h00);
    rchk(T0L + 8'h01, 8'h00);
    vec(1);
  endtask : t_split

  task t_counter();
    wr(T0L, 8'hFF);
    wr(T0L + 8'h01, 8'hFF);
    wr(CFG, 8'h05);
    wr(RUN, 8'h10);
    repeat (48) @(posedge CLK_I);
    rchk(T0L, 8'hFF);
    pins.count_event(0, 24);
    wait_flag(0, -1);
    wr(RUN, 8'h20);
    rchk(T0L, 8'h00);
    vec(0);
  endtask : t_counter

  task t_gate();
    wr(T0L, 8'hFE);
    wr(T0L + 8'h01, 8'hFF);
    wr(CFG, 8'h09);
    pins.set_line(0, 1'b0);
    wr(RUN, 8'h10);
    repeat (48) @(posedge CLK_I);
    rchk(T0L, 8'hFE);
    check({15'h0, flg[2]}, 16'h0001);
    pins.set_line(0, 1'b1);
    wait_flag(0, -1);
    wr(RUN, 8'h22);
    vec(0);
    vec(2);
  endtask : t_gate

  task t_edge();
    wr(RUN, 8'h05);
    for (int i = 0; i < 2; i++) begin
      pins.set_line(i, 1'b0);
      wait_flag(2 + i, -1);
      vec(2 + i);
      repeat (36) @(posedge CLK_I);
      #1;
      check({15'h0, flg[2 + i]}, 16'h0000);
      pins.set_line(i, 1'b1);
    end
    wr(RUN, 8'h00);
  endtask : t_edge

  // clock enable low freezes register writes
  task t_freeze();
    wr(T0L, 8'h11);
    @(posedge CLK_I);
    CE_I <= 1'b0;
    wr(T0L, 8'h77);
    wr(RUN, 8'h10);
    @(posedge CLK_I);
    CE_I <= 1'b1;
    rchk(T0L, 8'h11);
    rchk(RUN, 8'h00);
  endtask : t_freeze

  // reset in mid-run clears everything again
  task t_rerun();
    wr(T0L, 8'h5A);
    wr(CFG, 8'h11);
    wr(RUN, 8'h55);
    @(posedge CLK_I);
    SYS_RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    t_reset();
  endtask : t_rerun

  initial begin
    repeat (8) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    t_reset();
    t_regs();
    t_modes();
    t_split();
    t_counter();
    t_gate();
    t_edge();
    t_freeze();
    t_rerun();
    final_report();
  end
endmodule : tb
